// [logic/ciwt_consts.svh]
// Constants of the configurable interval watchdog timer: offsets, fields,
// reset values, timing. Included by the package and every design file.
`ifndef CIWT_CONSTS_SVH
`define CIWT_CONSTS_SVH

// ==========================================================
// Register offsets (word index, byte address = 4 * index)
`define CIWT_IDX_STATUS   4'h0
`define CIWT_IDX_CONTROL  4'h1
`define CIWT_IDX_PERIODL  4'h2
`define CIWT_IDX_PERIODH  4'h3
`define CIWT_IDX_SNAPL    4'h4
`define CIWT_IDX_SNAPH    4'h5
`define CIWT_IDX_IRQ_STAT 4'h6
`define CIWT_IDX_IRQ_MASK 4'h7

// ==========================================================
// Field positions
`define CIWT_ST_TO     0
`define CIWT_ST_RUN    1
`define CIWT_CT_ITO    0
`define CIWT_CT_CONT   1
`define CIWT_CT_START  2
`define CIWT_CT_STOP   3
`define CIWT_EV_ZERO   0
`define CIWT_EV_RESREQ 1

// ==========================================================
// Reset and read values
`define CIWT_CTRL_RST   4'h0
`define CIWT_MASK_RST   2'h0
`define CIWT_UNDEF_READ 16'h0000

// ==========================================================
// Timing
`define CIWT_CLK_HZ       25000000
`define CIWT_TIMEOUT_US   1000
`define CIWT_TIMEOUT_CYC  ((`CIWT_TIMEOUT_US * (`CIWT_CLK_HZ / 1000000)))

`endif

// [logic/ciwt_pkg.sv]
// Types of the configurable interval watchdog timer.
// Assumes ciwt_consts.svh is on the include path.
`include "ciwt_consts.svh"
package ciwt_pkg;
  typedef enum logic [1:0] {
    CIWT_IDLE,
    CIWT_RUN,
    CIWT_LOCKED
  } ciwt_state_t;
endpackage

// [logic/ciwt_regsel.sv]
// Register index decoder of the timer.
// Assumes strobes are one cycle and never both high.
`timescale 1ns/1ps
`default_nettype none
`include "ciwt_consts.svh"
module ciwt_regsel
  import ciwt_pkg::*;
(
  input  wire logic [3:0] addr,
  input  wire logic       wr,
  output logic            wr_status,
  output logic            wr_control,
  output logic            wr_periodl,
  output logic            wr_periodh,
  output logic            wr_snap,
  output logic            wr_irq_stat,
  output logic            wr_irq_mask
);
  function automatic logic hit(input logic [3:0] a, input logic [3:0] i);
    hit = (a == i);
  endfunction

  assign wr_status   = wr & hit(addr, `CIWT_IDX_STATUS);
  assign wr_control  = wr & hit(addr, `CIWT_IDX_CONTROL);
  assign wr_periodl  = wr & hit(addr, `CIWT_IDX_PERIODL);
  assign wr_periodh  = wr & hit(addr, `CIWT_IDX_PERIODH);
  assign wr_snap     = wr & (hit(addr, `CIWT_IDX_SNAPL) |
                             hit(addr, `CIWT_IDX_SNAPH));
  assign wr_irq_stat = wr & hit(addr, `CIWT_IDX_IRQ_STAT);
  assign wr_irq_mask = wr & hit(addr, `CIWT_IDX_IRQ_MASK);
endmodule
`default_nettype wire

// [logic/ciwt_irq.sv]
// Sticky event flags with write-one-to-clear and a mask.
// Assumes events are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ciwt_consts.svh"
module ciwt_irq
  import ciwt_pkg::*;
#(
  parameter int N = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [N-1:0] ev,
  input  wire logic         wr_stat,
  input  wire logic         wr_mask,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] stat,
  output logic      [N-1:0] mask,
  output logic              irq
);
  logic [N-1:0] stat_r;
  logic [N-1:0] mask_r;
  logic [N-1:0] stat_nxt;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // Set wins over clear
      assign stat_nxt[g] = ev[g] | (stat_r[g] & ~(wr_stat & wdata[g]));
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_r <= '0;
      mask_r <= '0;
    end else if (ce) begin
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= wdata;
      end
    end
  end

  assign stat = stat_r;
  assign mask = mask_r;
  assign irq  = |(stat_r & mask_r);
endmodule
`default_nettype wire

// [logic/ciwt_top.sv]
// Configurable interval watchdog timer: 32-bit count-down core.
// Assumes a single-clock master using the plain strobe register port.
`timescale 1ns/1ps
`default_nettype none
`include "ciwt_consts.svh"
module ciwt_top
  import ciwt_pkg::*;
#(
  parameter bit          WRITEABLE_PERIOD = 1'b1,
  parameter bit          READABLE_SNAP    = 1'b1,
  parameter bit          START_STOP       = 1'b1,
  parameter bit          TIMEOUT_PULSE    = 1'b1,
  parameter bit          WATCHDOG         = 1'b0,
  parameter logic [31:0] TIMEOUT_CYC      = 32'(`CIWT_TIMEOUT_CYC)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             irq,
  output logic             timeout_irq,
  output logic             timeout_pulse,
  output logic             reset_request
);
  // ==========================================================
  // Decode
  logic wr_status;
  logic wr_control;
  logic wr_periodl;
  logic wr_periodh;
  logic wr_snap;
  logic wr_irq_stat;
  logic wr_irq_mask;

  ciwt_regsel u_sel (
    .addr        (addr),
    .wr          (wr),
    .wr_status   (wr_status),
    .wr_control  (wr_control),
    .wr_periodl  (wr_periodl),
    .wr_periodh  (wr_periodh),
    .wr_snap     (wr_snap),
    .wr_irq_stat (wr_irq_stat),
    .wr_irq_mask (wr_irq_mask)
  );

  // ==========================================================
  // State
  localparam logic [31:0] RELOAD = TIMEOUT_CYC - 32'h1;
  localparam bit HAS_START = START_STOP | WATCHDOG;

  ciwt_state_t state_r;
  ciwt_state_t state_nxt;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] period_r;
  logic [31:0] snap_r;
  logic        to_r;
  logic        ito_r;
  logic        cont_r;
  logic        pulse_r;
  logic        resreq_r;
  logic [15:0] rdata_r;

  wire running    = (state_r != CIWT_IDLE);
  wire at_zero    = running && (count_r == 32'h0);
  wire start_req  = HAS_START && wr_control && wdata[`CIWT_CT_START];
  wire stop_req   = START_STOP && !WATCHDOG && wr_control &&
                    wdata[`CIWT_CT_STOP];
  wire kick       = WATCHDOG && (wr_periodl || wr_periodh);
  wire per_wr_en  = WRITEABLE_PERIOD && !WATCHDOG;
  wire one_shot_end = at_zero && !cont_r && START_STOP && !WATCHDOG;

  // Period currently in effect
  wire [31:0] period_cur = per_wr_en ? period_r : RELOAD;

  // ==========================================================
  // Run control
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CIWT_IDLE: begin
        if (start_req) begin
          state_nxt = WATCHDOG ? CIWT_LOCKED : CIWT_RUN;
        end
      end
      CIWT_RUN: begin
        if (stop_req || one_shot_end) begin
          state_nxt = CIWT_IDLE;
        end
      end
      CIWT_LOCKED: begin
        state_nxt = CIWT_LOCKED;
      end
      default: begin
        state_nxt = CIWT_IDLE;
      end
    endcase
  end

  always_comb begin
    count_nxt = count_r;
    if (kick) begin
      count_nxt = period_cur;
    end else if (at_zero) begin
      count_nxt = period_cur;
    end else if (running) begin
      count_nxt = count_r - 32'h1;
    end
  end

  // Without start control or watchdog the counter free-runs from reset
  localparam ciwt_state_t ST_RST = HAS_START ? CIWT_IDLE : CIWT_RUN;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= ST_RST;
      count_r <= RELOAD;
    end else if (ce) begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      period_r <= RELOAD;
      ito_r    <= 1'b0;
      cont_r   <= 1'b0;
    end else if (ce) begin
      if (per_wr_en && wr_periodl) begin
        period_r[15:0] <= wdata;
      end
      if (per_wr_en && wr_periodh) begin
        period_r[31:16] <= wdata;
      end
      if (wr_control) begin
        ito_r  <= wdata[`CIWT_CT_ITO];
        cont_r <= wdata[`CIWT_CT_CONT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      snap_r <= 32'h0;
    end else if (ce && READABLE_SNAP && wr_snap) begin
      snap_r <= count_r;
    end
  end

  // Timeout flag: set wins over any write to status
  always_ff @(posedge clk) begin
    if (!nrst) begin
      to_r <= 1'b0;
    end else if (ce) begin
      to_r <= at_zero | (to_r & ~wr_status);
    end
  end

  // ==========================================================
  // Zero-reached outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_r  <= 1'b0;
      resreq_r <= 1'b0;
    end else if (ce) begin
      pulse_r  <= TIMEOUT_PULSE && at_zero;
      resreq_r <= WATCHDOG && at_zero;
    end else begin
      pulse_r  <= 1'b0;
      resreq_r <= 1'b0;
    end
  end

  assign timeout_pulse = pulse_r;
  assign reset_request = resreq_r;
  assign timeout_irq   = to_r & ito_r;

  // ==========================================================
  // Interrupt status
  logic [1:0] ev_stat;
  logic [1:0] ev_mask;
  logic [1:0] ev_in;

  assign ev_in[`CIWT_EV_ZERO]   = ce & at_zero & ito_r;
  assign ev_in[`CIWT_EV_RESREQ] = ce & WATCHDOG & at_zero;

  ciwt_irq #(
    .N (2)
  ) u_irq (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .ev      (ev_in),
    .wr_stat (wr_irq_stat),
    .wr_mask (wr_irq_mask),
    .wdata   (wdata[1:0]),
    .stat    (ev_stat),
    .mask    (ev_mask),
    .irq     (irq)
  );

  // ==========================================================
  // Read path, data valid in the cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (addr)
      `CIWT_IDX_STATUS: begin
        rd_mux = {14'h0, running, to_r};
      end
      `CIWT_IDX_CONTROL: begin
        rd_mux = {14'h0, cont_r, ito_r};
      end
      `CIWT_IDX_PERIODL: begin
        rd_mux = per_wr_en ? period_r[15:0] : RELOAD[15:0];
      end
      `CIWT_IDX_PERIODH: begin
        rd_mux = per_wr_en ? period_r[31:16] : RELOAD[31:16];
      end
      `CIWT_IDX_SNAPL: begin
        rd_mux = READABLE_SNAP ? snap_r[15:0] : `CIWT_UNDEF_READ;
      end
      `CIWT_IDX_SNAPH: begin
        rd_mux = READABLE_SNAP ? snap_r[31:16] : `CIWT_UNDEF_READ;
      end
      `CIWT_IDX_IRQ_STAT: begin
        rd_mux = {14'h0, ev_stat};
      end
      `CIWT_IDX_IRQ_MASK: begin
        rd_mux = {14'h0, ev_mask};
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else if (ce) begin
      rdata_r <= rd ? rd_mux : 16'h0000;
    end
  end
  assign rdata = rdata_r;

  // ==========================================================
  // Checks
  property p_pulse_one;
    @(posedge clk) disable iff (!nrst)
      timeout_pulse |=> !timeout_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");

  property p_pulse_zero;
    @(posedge clk) disable iff (!nrst)
      (ce && at_zero && TIMEOUT_PULSE) |=> timeout_pulse;
  endproperty
  a_pulse_zero: assert property (p_pulse_zero) else $error("no pulse");

  property p_resreq;
    @(posedge clk) disable iff (!nrst)
      reset_request |-> (WATCHDOG && $past(at_zero)) ##1 !reset_request;
  endproperty
  a_resreq: assert property (p_resreq) else $error("bad reset request");

  property p_reload;
    @(posedge clk) disable iff (!nrst)
      (ce && at_zero && !kick) |=> (count_r == $past(period_cur));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");

  property p_dec;
    @(posedge clk) disable iff (!nrst)
      (ce && running && !at_zero && !kick) |=> (count_r == $past(count_r) - 1);
  endproperty
  a_dec: assert property (p_dec) else $error("count not decremented");

  property p_locked;
    @(posedge clk) disable iff (!nrst)
      (state_r == CIWT_LOCKED) |=> (state_r == CIWT_LOCKED);
  endproperty
  a_locked: assert property (p_locked) else $error("watchdog stopped");

  property p_kick;
    @(posedge clk) disable iff (!nrst)
      (ce && kick) |=> (count_r == RELOAD);
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not reload");

  property p_start;
    @(posedge clk) disable iff (!nrst)
      (ce && !running && start_req) |=> running;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");

  property p_fixed;
    @(posedge clk) disable iff (!nrst)
      (ce && at_zero && !per_wr_en) |=> (count_r == RELOAD);
  endproperty
  a_fixed: assert property (p_fixed) else $error("period not fixed");

  property p_wd_stopped;
    @(posedge clk) disable iff (!nrst)
      (WATCHDOG && $rose(nrst)) |-> !running;
  endproperty
  a_wd_stopped: assert property (p_wd_stopped) else $error("wd running");
endmodule
`default_nettype wire

// [tb/ciwt_master.sv]
// Bus master model driving the timer's plain strobe register port.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module ciwt_master (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  output logic      [3:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ==========================================================
  // Write: one strobe cycle, then the data lines stop holding
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  // ==========================================================
  // Read: answer taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// [tb/test_configurable_interval_watchdog_timer.sv]
// Testbench: a full-featured timer and a watchdog timer, each with a master.
// Assumes the short 16-cycle timeout for both instances.
`timescale 1ns/1ps
`default_nettype none
module test_configurable_interval_watchdog_timer;
  import ciwt_pkg::*;
  logic        clk;
  logic        nrst;
  logic [3:0]  a_addr, w_addr;
  logic [15:0] a_wdata, w_wdata, a_rdata, w_rdata, d;
  logic        a_wr, a_rd, w_wr, w_rd;
  logic        irq, t_irq, t_pulse, rst_req;
  logic        ce, a_rr, w_irq, w_tirq, w_pulse;
  int          errors, comparisons, n, n_rr;

  ciwt_top #(.TIMEOUT_CYC(32'h10)) ciwt_top_i (.clk(clk), .nrst(nrst),
    .ce(ce), .addr(a_addr), .wdata(a_wdata), .wr(a_wr), .rd(a_rd),
    .rdata(a_rdata), .irq(irq), .timeout_irq(t_irq),
    .timeout_pulse(t_pulse), .reset_request(a_rr));
  ciwt_top #(.READABLE_SNAP(1'b0), .START_STOP(1'b0), .WATCHDOG(1'b1),
    .TIMEOUT_CYC(32'h10)) ciwt_top_wd_i (.clk(clk), .nrst(nrst),
    .ce(ce), .addr(w_addr), .wdata(w_wdata), .wr(w_wr), .rd(w_rd),
    .rdata(w_rdata), .irq(w_irq), .timeout_irq(w_tirq),
    .timeout_pulse(w_pulse), .reset_request(rst_req));
  ciwt_master ciwt_master_i (.clk(clk), .rdata(a_rdata), .addr(a_addr),
    .wdata(a_wdata), .wr(a_wr), .rd(a_rd));
  ciwt_master ciwt_master_wd_i (.clk(clk), .rdata(w_rdata), .addr(w_addr),
    .wdata(w_wdata), .wr(w_wr), .rd(w_rd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) if (rst_req === 1'b1) n_rr++;

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cycles until the next pulse, 100 if none comes
  task automatic wait_ev(input bit w, output int k);
    k = 0;
    @(negedge clk);
    while ((w ? rst_req : t_pulse) !== 1'b1 && k < 100) begin
      k++;
      @(negedge clk);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk({irq, t_irq, t_pulse, rst_req, a_rr, w_irq, w_tirq, w_pulse}, 8'h00);
    ciwt_master_i.wr_reg(4'h4, 16'h0000);
    ciwt_master_i.rd_reg(4'h4, d);
    chk(d, 16'h000f);
    ciwt_master_i.rd_reg(4'h5, d);
    chk(d, 16'h0000);
    ciwt_master_i.rd_reg(4'h8, d);
    chk(d, 16'h0000);
    ciwt_master_wd_i.wr_reg(4'h4, 16'h0000);
    ciwt_master_wd_i.rd_reg(4'h4, d);
    chk(d, 16'h0000);
  endtask

  task automatic t_period;
    ciwt_master_i.wr_reg(4'h2, 16'h0007);
    ciwt_master_i.wr_reg(4'h3, 16'h0000);
    ciwt_master_i.wr_reg(4'h1, 16'h0006);
    wait_ev(1'b0, n);
    wait_ev(1'b0, n);
    wait_ev(1'b0, n);
    chk(n, 7);
    chk(a_rr, 1'b0);
  endtask

  // Clock enable low must stall the count and ignore the bus
  task automatic t_freeze;
    wait_ev(1'b0, n);
    @(posedge clk);
    ce <= 1'b0;
    wait_ev(1'b0, n);
    chk(n, 100);
    ciwt_master_i.wr_reg(4'h7, 16'h0003);
    @(posedge clk);
    ce <= 1'b1;
    ciwt_master_i.rd_reg(4'h7, d);
    chk(d, 16'h0000);
    wait_ev(1'b0, n);
    chk(n < 8, 1'b1);
  endtask

  task automatic t_stop_irq;
    ciwt_master_i.wr_reg(4'h7, 16'h0000);
    ciwt_master_i.wr_reg(4'h1, 16'h0007);
    wait_ev(1'b0, n);
    ciwt_master_i.wr_reg(4'h1, 16'h0009);
    ciwt_master_i.rd_reg(4'h0, d);
    chk(d, 16'h0001);
    chk({irq, t_irq}, 2'h1);
    wait_ev(1'b0, n);
    chk(n, 100);
    ciwt_master_i.rd_reg(4'h6, d);
    chk(d[0], 1'b1);
    ciwt_master_i.wr_reg(4'h7, 16'h0001);
    ciwt_master_i.rd_reg(4'h0, d);
    chk(irq, 1'b1);
    ciwt_master_i.wr_reg(4'h6, 16'h0001);
    ciwt_master_i.wr_reg(4'h0, 16'h0000);
    ciwt_master_i.rd_reg(4'h0, d);
    chk(d, 16'h0000);
    chk({irq, t_irq}, 2'h0);
  endtask

  task automatic t_watchdog;
    wait_ev(1'b1, n);
    chk(n, 100);
    ciwt_master_wd_i.wr_reg(4'h1, 16'h0004);
    for (int i = 0; i < 6; i++) begin
      repeat (8) @(posedge clk);
      ciwt_master_wd_i.wr_reg(4'(2 + i % 2), 16'h1234);
    end
    chk(n_rr, 0);
    ciwt_master_wd_i.wr_reg(4'h1, 16'h0008);
    ciwt_master_wd_i.rd_reg(4'h0, d);
    chk(d[1], 1'b1);
    wait_ev(1'b1, n);
    chk(n < 20, 1'b1);
    wait_ev(1'b1, n);
    chk(n, 15);
    chk(w_pulse, 1'b1);
    chk({w_irq, w_tirq}, 2'h0);
  endtask

  // A second reset must stop a started watchdog
  task automatic t_rerun;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({rst_req, w_pulse, t_pulse, irq}, 4'h0);
    ciwt_master_wd_i.rd_reg(4'h0, d);
    chk(d, 16'h0000);
    wait_ev(1'b1, n);
    chk(n, 100);
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    n_rr = 0;
    nrst <= 1'b0;
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    t_reset();
    t_period();
    t_freeze();
    t_stop_irq();
    t_watchdog();
    t_rerun();
    end_sim();
  end

  initial begin
    #200us;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
